// File: rtl/gpib_dev_core.sv
// Purpose: instrument-side bus interface: addressing, handshakes, remote/local, service request
// Assumes: bus pins synchronous to mclk, true logic; open-drain lines resolved outside
// Notes: received data bytes pass to the command parser through a 16-word FIFO
//
// Functional notes
// - addressed only by own address under attention
// - addresses 0..30, talk from @, listen from space
// - full source handshake when talking
// - full acceptor handshake for every byte
// - talker with poll, talk-only, unaddressed by listen address
// - listener unaddressed by own talk address
// - secondary addresses ignored, primary only
// - service request raised on enabled status condition
// - full remote/local including lockout state
// - universal and selected device clear honoured
// - parallel poll ignored, never answered
// - trigger ignored, never bus controller
// - talk-only or addressable, no listen-only
// - local after reset, bus data bytes then dropped; commands under attention still decoded
// - leave remote on panel, go-local or text command
// - lockout blocks panel local request
// - lockout still on bus gives lockout remote
// - remote disables panel except page/cursor keys
// - talk-only only with serial port remote control
// - serial poll returns status, withdraws request
// - panel request in lockout sets bit 2
// - device clear flushes, resets mask, status, ready
// - interface clear unaddresses listener and talker (talk-only stays talker), ends serial poll
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// fifo with registered flags so the consumer side sees flop outputs
module gpib_rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  input wire logic flush,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];    // storage words
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;               // words held
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [AW:0] next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  // pointers and flags; flush drops content at once
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else if (flush) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
      count <= next_count;
      in_ready <= next_count != (AW+1)'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

  // storage has no reset, it is only read behind valid
  always_ff @(posedge mclk) begin
    if (push) mem[wr_ptr] <= in_data;
  end

  assign out_data = mem[rd_ptr];
endmodule

////////////////////////////////////////////////////////////////////////////////
module gpib_dev_core (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // configuration
  input wire logic [4:0] bus_addr,
  input wire logic bus_remote_sel,
  input wire logic talk_only_sel,
  // bus data and handshake lines
  input wire logic [7:0] dio_in,
  output logic [7:0] dio_out,
  output logic dio_oe,
  input wire logic dav_in,
  output logic dav_out,
  output logic dav_oe,
  input wire logic nrfd_in,
  output logic nrfd_out,
  output logic nrfd_oe,
  input wire logic ndac_in,
  output logic ndac_out,
  output logic ndac_oe,
  // bus management lines
  input wire logic atn_in,
  input wire logic ren_in,
  input wire logic ifc_in,
  output logic srq_out,
  output logic srq_oe,
  // instrument side
  input wire logic [7:0] status_in,
  input wire logic mask_wr,
  input wire logic [7:0] mask_data,
  input wire logic front_panel_local,
  input wire logic go_local_text_command,
  input wire logic ready_clr,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ack,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  // state indications
  output logic is_talker,
  output logic is_listener,
  output logic is_remote,
  output logic remote_with_lockout_state,
  output logic front_panel_enable,
  output logic serial_remote_active,
  output logic device_clear,
  output logic ready_ind
);
  typedef enum logic [1:0] {A_IDLE = 2'b00, A_HOLD = 2'b01, A_WAIT = 2'b10} acc_e;
  typedef enum logic [1:0] {S_IDLE = 2'b00, S_SETTLE = 2'b01, S_DAV = 2'b10, S_END = 2'b11} src_e;
  typedef enum logic [1:0] {LOCS = 2'b00, REMS = 2'b01, LWLS = 2'b10, LOCK_REM = 2'b11} rl_e;

  acc_e acc_state;
  src_e src_state;
  rl_e rl_state;
  logic poll_mode;                  // serial poll active
  logic lockout;                    // lockout message seen while remote enable held
  logic front_panel_request_bit;    // status bit 2
  logic srq_pending;                // request service
  logic cond_q;                     // previous service condition
  logic [7:0] srq_mask;
  logic sending_poll;               // byte on the lines is the status byte
  logic fifo_in_ready;

  //////////////////////////////////////////////////////////////////////////////
  // address and command decode on the byte under the lines; bit 7 is parity
  function automatic logic is_cmd(input logic [7:0] b, input logic [7:0] code);
    return {1'b0, b[6:0]} == code;
  endfunction

  wire addr_ok = bus_addr <= gpib_dev_pkg::MAX_ADDR;
  wire [7:0] own_listen_address = gpib_dev_pkg::LISTEN_BASE + {3'h0, bus_addr};
  wire [7:0] own_talk_address = gpib_dev_pkg::TALK_BASE + {3'h0, bus_addr};
  wire talk_only = talk_only_sel && !bus_remote_sel;
  wire addressable = bus_remote_sel && !talk_only;
  wire acc_active = atn_in || is_listener;
  wire byte_take = acc_state == A_IDLE && dav_in && acc_active && !nrfd_oe;
  wire cmd_take = byte_take && atn_in && addressable;
  // secondary codes (0x60 and up) never match any decode below
  wire hit_listen_addr = cmd_take && addr_ok && is_cmd(dio_in, own_listen_address);
  wire hit_talk_addr = cmd_take && addr_ok && is_cmd(dio_in, own_talk_address);
  wire hit_unl = cmd_take && is_cmd(dio_in, gpib_dev_pkg::UNLISTEN);
  wire hit_unt = cmd_take && is_cmd(dio_in, gpib_dev_pkg::UNTALK);
  wire hit_gtl = cmd_take && is_listener && is_cmd(dio_in, gpib_dev_pkg::CMD_GO_LOCAL);
  wire hit_sdc = cmd_take && is_listener && is_cmd(dio_in, gpib_dev_pkg::CMD_SEL_CLEAR);
  wire hit_dcl = cmd_take && is_cmd(dio_in, gpib_dev_pkg::CMD_DEV_CLEAR);
  wire hit_llo = cmd_take && is_cmd(dio_in, gpib_dev_pkg::CMD_LOCKOUT);
  wire hit_spe = cmd_take && is_cmd(dio_in, gpib_dev_pkg::CMD_POLL_ENABLE);
  wire hit_spd = cmd_take && is_cmd(dio_in, gpib_dev_pkg::CMD_POLL_DISABLE);
  // trigger and parallel poll codes fall through with no effect
  wire do_clear = hit_dcl || hit_sdc;
  // state decode, not the registered flag, so a go-local stops data at once
  wire in_remote = rl_state == REMS || rl_state == LOCK_REM;
  wire data_take = byte_take && !atn_in && in_remote;
  wire [7:0] status_byte = {status_in[7], srq_pending, status_in[5:3], front_panel_request_bit, status_in[1:0]};
  wire service_cond = |(status_byte & srq_mask & ~(8'h01 << gpib_dev_pkg::RSV_BIT));
  wire poll_done = src_state == S_DAV && !ndac_in && sending_poll;
  wire src_load = src_state == S_IDLE && is_talker && !atn_in && (poll_mode || tx_valid);
  wire panel_refused = front_panel_local && rl_state == LOCK_REM;

  //////////////////////////////////////////////////////////////////////////////
  // received data stream to the command parser
  gpib_rx_fifo #(.WIDTH(gpib_dev_pkg::FIFO_WIDTH), .DEPTH(gpib_dev_pkg::FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .resetn(resetn),
    .flush(device_clear),
    .in_valid(data_take),
    .in_data(dio_in),
    .in_ready(fifo_in_ready),
    .out_valid(rx_valid),
    .out_data(rx_data),
    .out_ready(rx_ready)
  );

  //////////////////////////////////////////////////////////////////////////////
  // acceptor: ndac held until byte taken, nrfd held while fifo full (back-pressure)
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      acc_state <= A_IDLE;
      nrfd_oe <= 1'b0;
      ndac_oe <= 1'b0;
    end else if (!acc_active || ifc_in) begin
      acc_state <= A_IDLE;          // not participating: both lines released
      nrfd_oe <= 1'b0;
      ndac_oe <= 1'b0;
    end else begin
      case (acc_state)
        A_IDLE: begin
          ndac_oe <= 1'b1;
          nrfd_oe <= !(atn_in || fifo_in_ready);
          if (byte_take) begin
            acc_state <= A_HOLD;
            nrfd_oe <= 1'b1;
          end
        end
        A_HOLD: begin
          ndac_oe <= 1'b0;          // byte is accepted
          acc_state <= A_WAIT;
        end
        A_WAIT: begin
          if (!dav_in) begin
            ndac_oe <= 1'b1;
            acc_state <= A_IDLE;
          end
        end
        default: acc_state <= A_IDLE;
      endcase
    end
  end
  assign nrfd_out = nrfd_oe;
  assign ndac_out = ndac_oe;

  //////////////////////////////////////////////////////////////////////////////
  // source: data placed, wait ready for data, raise dav, wait accepted
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      src_state <= S_IDLE;
      dio_out <= 8'h00;
      dio_oe <= 1'b0;
      dav_oe <= 1'b0;
      sending_poll <= 1'b0;
      tx_ack <= 1'b0;
    end else begin
      tx_ack <= 1'b0;
      if (atn_in || !is_talker || ifc_in) begin
        src_state <= S_IDLE;        // controller took the bus
        dio_oe <= 1'b0;
        dav_oe <= 1'b0;
      end else begin
        case (src_state)
          S_IDLE: begin
            if (src_load) begin
              dio_out <= poll_mode ? status_byte : tx_data;
              sending_poll <= poll_mode;
              tx_ack <= !poll_mode;
              dio_oe <= 1'b1;
              src_state <= S_SETTLE;
            end
          end
          S_SETTLE: begin
            if (!nrfd_in && ndac_in) begin
              dav_oe <= 1'b1;
              src_state <= S_DAV;
            end
          end
          S_DAV: begin
            if (!ndac_in) begin
              dav_oe <= 1'b0;
              src_state <= S_END;
            end
          end
          S_END: begin
            dio_oe <= 1'b0;
            src_state <= S_IDLE;
          end
          default: src_state <= S_IDLE;
        endcase
      end
    end
  end
  assign dav_out = dav_oe;

  //////////////////////////////////////////////////////////////////////////////
  // talker/listener addressing and serial poll mode
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      is_talker <= 1'b0;
      is_listener <= 1'b0;
      poll_mode <= 1'b0;
    end else if (ifc_in) begin
      is_talker <= talk_only;
      is_listener <= 1'b0;
      poll_mode <= 1'b0;
    end else if (talk_only) begin
      is_talker <= 1'b1;
      is_listener <= 1'b0;
    end else begin
      if (hit_listen_addr || hit_unl) is_listener <= hit_listen_addr;
      else if (hit_talk_addr) is_listener <= 1'b0;
      if (hit_talk_addr || hit_unt) is_talker <= hit_talk_addr;
      else if (hit_listen_addr) is_talker <= 1'b0;
      if (hit_spe) poll_mode <= 1'b1;
      else if (hit_spd) poll_mode <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // remote/local states; remote enable low forces local and drops lockout
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rl_state <= LOCS;
      lockout <= 1'b0;
    end else if (!ren_in || !addressable) begin
      rl_state <= LOCS;
      lockout <= 1'b0;
    end else begin
      if (hit_llo) lockout <= 1'b1;
      case (rl_state)
        LOCS: if (hit_listen_addr) rl_state <= (lockout || hit_llo) ? LOCK_REM : REMS;
        else if (hit_llo) rl_state <= LWLS;
        REMS: if (hit_gtl || go_local_text_command || front_panel_local) rl_state <= LOCS;
        else if (hit_llo) rl_state <= LOCK_REM;
        LWLS: if (hit_listen_addr) rl_state <= LOCK_REM;
        LOCK_REM: if (hit_gtl || go_local_text_command) rl_state <= LWLS;
        default: rl_state <= LOCS;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // service request, request mask, device clear and ready indication
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      srq_pending <= 1'b0;
      front_panel_request_bit <= 1'b0;
      cond_q <= 1'b0;
      srq_mask <= gpib_dev_pkg::MASK_ERR_ONLY;
      device_clear <= 1'b0;
      ready_ind <= 1'b1;
    end else begin
      device_clear <= do_clear;
      cond_q <= service_cond;
      if (do_clear) begin
        srq_pending <= 1'b0;
        front_panel_request_bit <= 1'b0;
        srq_mask <= gpib_dev_pkg::MASK_ERR_ONLY;
        ready_ind <= 1'b1;
      end else begin
        if (mask_wr) srq_mask <= mask_data;
        if (service_cond && !cond_q) srq_pending <= 1'b1;
        else if (poll_done) srq_pending <= 1'b0;
        if (ready_clr) ready_ind <= 1'b0;
      end
      // a panel request in the clear cycle survives: set wins over clear
      if (panel_refused) front_panel_request_bit <= 1'b1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered indications
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      srq_oe <= 1'b0;
      is_remote <= 1'b0;
      remote_with_lockout_state <= 1'b0;
      front_panel_enable <= 1'b1;
      serial_remote_active <= 1'b0;
    end else begin
      srq_oe <= srq_pending && !do_clear && !poll_done;
      is_remote <= in_remote;
      remote_with_lockout_state <= rl_state == LOCK_REM;
      front_panel_enable <= !in_remote;
      serial_remote_active <= !bus_remote_sel;
    end
  end
  assign srq_out = srq_oe;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  chk_talk_listen_excl: assert property (@(posedge mclk) disable iff (!resetn)
    !(is_talker && is_listener)) else $error("talker and listener at once");
  chk_listen_addr: assert property (@(posedge mclk) disable iff (!resetn)
    hit_listen_addr && !ifc_in && !talk_only |=> is_listener && !is_talker) else $error("listen address missed");
  chk_talk_addr: assert property (@(posedge mclk) disable iff (!resetn)
    hit_talk_addr && !ifc_in && !talk_only |=> is_talker && !is_listener) else $error("talk address missed");
  chk_remote_entry: assert property (@(posedge mclk) disable iff (!resetn)
    hit_listen_addr && ren_in && rl_state == LOCS && !lockout && !hit_llo |=> ##1 is_remote)
    else $error("remote not entered");
  chk_lockout_hold: assert property (@(posedge mclk) disable iff (!resetn)
    rl_state == LOCK_REM && ren_in && addressable && !hit_gtl && !go_local_text_command |=> rl_state == LOCK_REM)
    else $error("left lockout remote");
  chk_panel_bit: assert property (@(posedge mclk) disable iff (!resetn)
    panel_refused |=> front_panel_request_bit) else $error("panel request bit not set");
  chk_clear_effects: assert property (@(posedge mclk) disable iff (!resetn)
    do_clear |=> device_clear && !srq_pending && ready_ind && srq_mask == gpib_dev_pkg::MASK_ERR_ONLY)
    else $error("device clear incomplete");
  chk_poll_withdraw: assert property (@(posedge mclk) disable iff (!resetn)
    poll_done && !(service_cond && !cond_q) && !do_clear |=> ##1 !srq_oe) else $error("request not withdrawn");
  chk_dav_guard: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(dav_oe) |-> dio_oe && !$past(nrfd_in)) else $error("data valid before ready");
  chk_local_drop: assert property (@(posedge mclk) disable iff (!resetn)
    rl_state == LOCS || rl_state == LWLS |-> !data_take) else $error("data taken while local");
  cov_remote: cover property (@(posedge mclk) disable iff (!resetn) $rose(is_remote));
  cov_lockout: cover property (@(posedge mclk) disable iff (!resetn) $rose(remote_with_lockout_state));
  cov_poll: cover property (@(posedge mclk) disable iff (!resetn) poll_done);
  cov_fifo_full: cover property (@(posedge mclk) disable iff (!resetn) !fifo_in_ready);
endmodule

// File: rtl/gpib_dev_pkg.sv
// Purpose: shared constants for the instrument-side bus interface
// Assumes: bus lines are presented in true logic (1 = asserted)
// Notes: command codes are the standard universal/addressed bus messages
package gpib_dev_pkg;
  // address characters: listen at 0x20 + addr, talk at 0x40 + addr
  localparam logic [7:0] LISTEN_BASE = 8'h20;
  localparam logic [7:0] TALK_BASE = 8'h40;
  localparam logic [4:0] MAX_ADDR = 5'h1E;
  localparam logic [7:0] UNLISTEN = 8'h3F;
  localparam logic [7:0] UNTALK = 8'h5F;
  localparam logic [7:0] SECONDARY_BASE = 8'h60;
  // addressed and universal commands
  localparam logic [7:0] CMD_GO_LOCAL = 8'h01;
  localparam logic [7:0] CMD_SEL_CLEAR = 8'h04;
  localparam logic [7:0] CMD_TRIGGER = 8'h08;
  localparam logic [7:0] CMD_LOCKOUT = 8'h11;
  localparam logic [7:0] CMD_DEV_CLEAR = 8'h14;
  localparam logic [7:0] CMD_POLL_ENABLE = 8'h18;
  localparam logic [7:0] CMD_POLL_DISABLE = 8'h19;
  // status byte layout
  localparam int PANEL_REQ_BIT = 2;
  localparam int RSV_BIT = 6;
  // request mask after device clear: error bit only
  localparam logic [7:0] MASK_ERR_ONLY = 8'h20;
  localparam int FIFO_DEPTH = 16;
  localparam int FIFO_WIDTH = 8;
endpackage

// File: test/gpib_ctl_model.sv
// Purpose: bus controller model facing the instrument interface
// Assumes: true logic; a released line reads 0 (terminated wire)
// Notes: drives after the falling edge; every wait is bounded
`timescale 1ns/10ps
////////////////////////////////////////
module gpib_ctl_model (
  // clock
  input wire logic mclk,
  // resolved wires
  input wire logic [7:0] dio_w,
  input wire logic dav_w,
  input wire logic nrfd_w,
  input wire logic ndac_w,
  // controller drive
  output logic [7:0] dio_m,
  output logic dav_m,
  output logic nrfd_m,
  output logic ndac_m,
  output logic atn,
  output logic ren,
  output logic ifc
);
  // everything released at start
  initial begin
    dio_m = 8'h00;
    {dav_m, nrfd_m, ndac_m, atn, ren, ifc} = 6'h00;
  end
  // management lines; ren before the listen address gives remote
  task automatic mgmt(input logic r, input logic i);
    @(negedge mclk);
    ren = r;
    ifc = i;
  endtask
  // source one byte; ok low when the acceptor never became ready
  task automatic put(input logic a, input logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(negedge mclk);
    atn = a;
    {nrfd_m, ndac_m} = 2'h0;
    @(negedge mclk);
    while (nrfd_w && n < 40) begin
      @(negedge mclk);
      n++;
    end
    if (!nrfd_w) begin
      dio_m = b;
      @(negedge mclk);
      dav_m = 1'b1;
      n = 0;
      while (ndac_w && n < 40) begin
        @(negedge mclk);
        n++;
      end
      ok = !ndac_w;
      dav_m = 1'b0;
      // released data reads false, never the old byte
      dio_m = 8'h00;
    end
  endtask
  // accept one talker byte, then hold not-ready so nothing follows
  task automatic get(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    b = 8'h00;
    @(negedge mclk);
    atn = 1'b0;
    {nrfd_m, ndac_m} = 2'h1;
    while (!dav_w && n < 60) begin
      @(negedge mclk);
      n++;
    end
    if (dav_w) begin
      b = dio_w;
      ok = 1'b1;
      {nrfd_m, ndac_m} = 2'h2;
      n = 0;
      while (dav_w && n < 40) begin
        @(negedge mclk);
        n++;
      end
      ndac_m = 1'b1;
    end
  endtask
endmodule

// File: test/testbench.sv
// Purpose: self-checking bench for the instrument bus interface
// Assumes: 200 MHz mclk; inputs change at the falling edge
// Notes: own address is 30, the top of the range
`timescale 1ns/10ps
////////////////////////////////////////
module testbench;
  // design inputs
  logic mclk, resetn, bus_remote_sel, talk_only_sel;
  logic [4:0] bus_addr;
  logic [7:0] status_in, mask_data, tx_data;
  logic mask_wr, front_panel_local, go_local_text_command, ready_clr, tx_valid, rx_ready;
  // design outputs
  logic [7:0] dio_out, rx_data;
  logic dio_oe, dav_out, dav_oe, nrfd_out, nrfd_oe, ndac_out, ndac_oe, srq_out, srq_oe;
  logic tx_ack, rx_valid, is_talker, is_listener, is_remote, remote_with_lockout_state;
  logic front_panel_enable, serial_remote_active, device_clear, ready_ind;
  // controller drive and resolved wires
  logic [7:0] dio_m, dio_in;
  logic dav_m, nrfd_m, ndac_m, atn_in, ren_in, ifc_in, dav_in, nrfd_in, ndac_in;
  // bookkeeping
  int n_fail = 0;
  int samples_checked = 0;
  logic dc_seen, ack_seen;
  localparam logic [4:0] ADDR = gpib_dev_pkg::MAX_ADDR;
  localparam logic [7:0] LA = gpib_dev_pkg::LISTEN_BASE + {3'h0, ADDR};
  localparam logic [7:0] TA = gpib_dev_pkg::TALK_BASE + {3'h0, ADDR};
  // wired-or of both parties
  assign dio_in = dio_m | (dio_oe ? dio_out : 8'h00);
  assign dav_in = dav_m | (dav_out & dav_oe);
  assign nrfd_in = nrfd_m | (nrfd_out & nrfd_oe);
  assign ndac_in = ndac_m | (ndac_out & ndac_oe);
  gpib_dev_core dut (
    .mclk, .resetn, .bus_addr, .bus_remote_sel, .talk_only_sel, .dio_in, .dio_out, .dio_oe,
    .dav_in, .dav_out, .dav_oe, .nrfd_in, .nrfd_out, .nrfd_oe, .ndac_in, .ndac_out, .ndac_oe,
    .atn_in, .ren_in, .ifc_in, .srq_out, .srq_oe, .status_in, .mask_wr, .mask_data,
    .front_panel_local, .go_local_text_command, .ready_clr, .tx_valid, .tx_data, .tx_ack,
    .rx_valid, .rx_data, .rx_ready, .is_talker, .is_listener, .is_remote,
    .remote_with_lockout_state, .front_panel_enable, .serial_remote_active, .device_clear,
    .ready_ind
  );
  gpib_ctl_model m (
    .mclk, .dio_w(dio_in), .dav_w(dav_in), .nrfd_w(nrfd_in), .ndac_w(ndac_in), .dio_m,
    .dav_m, .nrfd_m, .ndac_m, .atn(atn_in), .ren(ren_in), .ifc(ifc_in)
  );
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  // one-cycle pulses are caught here so checks need not hit the cycle
  always @(posedge mclk) begin
    if (device_clear === 1'b1) dc_seen <= 1'b1;
    if (tx_ack === 1'b1) ack_seen <= 1'b1;
  end
  ////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic do_reset();
    @(negedge mclk);
    resetn = 1'b0;
    tick(5);
    resetn = 1'b1;
    tick(2);
  endtask
  // command byte under attention, always handshaken
  task automatic cmd(input logic [7:0] b);
    logic ok;
    m.put(1'b1, b, ok);
    check(ok, 8'h01);
    tick(3);
  endtask
  task automatic set_mask(input logic [7:0] v);
    @(negedge mclk);
    mask_data = v;
    mask_wr = 1'b1;
    @(negedge mclk);
    mask_wr = 1'b0;
  endtask
  task automatic panel();
    front_panel_local = 1'b1;
    tick(1);
    front_panel_local = 1'b0;
    tick(4);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    check({is_talker, is_listener, is_remote, remote_with_lockout_state, srq_oe}, 8'h00);
    check({front_panel_enable, ready_ind}, 8'h03);
  endtask
  task automatic t_address();
    logic ok;
    cmd(LA);
    check({is_listener, is_remote}, 8'h02);
    m.put(1'b0, 8'h55, ok);
    tick(3);
    check(rx_valid, 8'h00);
    cmd(gpib_dev_pkg::UNLISTEN);
    m.mgmt(1'b1, 1'b0);
    cmd(LA - 8'h01);
    check(is_listener, 8'h00);
    cmd(gpib_dev_pkg::SECONDARY_BASE + {3'h0, ADDR});
    check(is_listener, 8'h00);
    cmd(LA);
    check({is_listener, is_remote, front_panel_enable}, 8'h06);
    cmd(TA);
    check({is_talker, is_listener}, 8'h02);
    cmd(LA);
    check({is_talker, is_listener}, 8'h01);
    cmd(gpib_dev_pkg::CMD_TRIGGER);
    cmd(8'h05);
    check({dio_oe, is_talker, is_listener}, 8'h01);
    m.mgmt(1'b1, 1'b1);
    m.mgmt(1'b1, 1'b0);
    tick(2);
    check(is_listener, 8'h00);
  endtask
  // fill to refusal with the consumer stalled, then drain in order
  task automatic t_fifo();
    logic ok;
    int n;
    cmd(LA);
    for (int i = 0; i < gpib_dev_pkg::FIFO_DEPTH; i++) begin
      m.put(1'b0, 8'h30 + 8'(i), ok);
      check(ok, 8'h01);
    end
    m.put(1'b0, 8'hEE, ok);
    check(ok, 8'h00);
    check({nrfd_out, ndac_out}, 8'h03);
    for (int i = 0; i < gpib_dev_pkg::FIFO_DEPTH; i++) begin
      n = 0;
      while (rx_valid !== 1'b1 && n < 20) begin
        tick(1);
        n++;
      end
      check(rx_data, 8'h30 + 8'(i));
      rx_ready = 1'b1;
      tick(1);
      rx_ready = 1'b0;
      tick(1);
    end
    check(rx_valid, 8'h00);
  endtask
  task automatic t_poll();
    logic ok;
    logic [7:0] b;
    set_mask(8'h01);
    status_in = 8'h01;
    tick(3);
    check({srq_out, srq_oe}, 8'h03);
    cmd(gpib_dev_pkg::UNLISTEN);
    cmd(gpib_dev_pkg::CMD_POLL_ENABLE);
    cmd(TA);
    m.get(b, ok);
    check(b, 8'h41);
    tick(2);
    check({srq_out, srq_oe}, 8'h00);
    cmd(gpib_dev_pkg::CMD_POLL_DISABLE);
    cmd(gpib_dev_pkg::UNTALK);
    check(is_talker, 8'h00);
  endtask
  task automatic t_lockout();
    set_mask(8'h04);
    cmd(LA);
    panel();
    check(is_remote, 8'h00);
    cmd(LA);
    cmd(gpib_dev_pkg::CMD_LOCKOUT);
    check(remote_with_lockout_state, 8'h01);
    panel();
    check({is_remote, srq_oe}, 8'h03);
    cmd(gpib_dev_pkg::CMD_GO_LOCAL);
    check(is_remote, 8'h00);
    cmd(gpib_dev_pkg::UNLISTEN);
    cmd(LA);
    check(remote_with_lockout_state, 8'h01);
    go_local_text_command = 1'b1;
    tick(1);
    go_local_text_command = 1'b0;
    tick(3);
    check(is_remote, 8'h00);
  endtask
  task automatic t_clear();
    ready_clr = 1'b1;
    tick(1);
    ready_clr = 1'b0;
    tick(1);
    check(ready_ind, 8'h00);
    dc_seen = 1'b0;
    cmd(gpib_dev_pkg::CMD_DEV_CLEAR);
    check({dc_seen, srq_oe, ready_ind}, 8'h05);
    status_in = 8'h21;
    tick(3);
    check(srq_oe, 8'h01);
    dc_seen = 1'b0;
    cmd(gpib_dev_pkg::CMD_SEL_CLEAR);
    check(dc_seen, 8'h01);
  endtask
  task automatic t_talk_only();
    logic ok;
    logic [7:0] b;
    talk_only_sel = 1'b1;
    do_reset();
    check({is_talker, serial_remote_active}, 8'h00);
    bus_remote_sel = 1'b0;
    do_reset();
    check({is_talker, is_listener, serial_remote_active}, 8'h05);
    tx_data = 8'hA5;
    tx_valid = 1'b1;
    m.get(b, ok);
    tx_valid = 1'b0;
    check(b, 8'hA5);
    check({ok, ack_seen}, 8'h03);
  endtask
  ////////////////////////////////////////
  initial begin
    resetn = 1'b0;
    {bus_remote_sel, talk_only_sel, bus_addr} = {2'h2, ADDR};
    {status_in, mask_data, tx_data} = 24'h000000;
    {mask_wr, front_panel_local, go_local_text_command, ready_clr, tx_valid, rx_ready} = 6'h00;
    {dc_seen, ack_seen} = 2'h0;
    do_reset();
    t_reset();
    t_address();
    t_fifo();
    t_poll();
    t_lockout();
    t_clear();
    t_talk_only();
    conclude();
  end
  // watchdog well past the expected few hundred cycles
  initial begin
    repeat (20000) @(posedge mclk);
    n_fail++;
    $display("mismatch at %0t: run hung", $time);
    conclude();
  end
endmodule
